// file: dsci_pkg.sv
// constants, command codes and burst helpers for the ddr command and data block
package dsci_pkg;
   // array geometry
   localparam int DQ_W     = 16;
   localparam int BA_W     = 2;
   localparam int AD_W     = 13;
   localparam int COL_W    = 9;
   localparam int NBANK    = 4;
   localparam int ROWS     = 8192;
   localparam int COLS     = 512;
   localparam int MEM_AW   = 8;
   localparam int FIFO_D   = 4;
   // mode register fields
   localparam int MR_BL_LSB     = 0;
   localparam int MR_BT_BIT     = 3;
   localparam int MR_CL_LSB     = 4;
   localparam int MR_OP_LSB     = 7;
   localparam int MR_DLLRST_BIT = 8;
   localparam int EMR_DLLDIS_BIT = 0;
   localparam int AP_BIT        = 10;
   localparam logic [1:0] BA_MR  = 2'h0;
   localparam logic [1:0] BA_EMR = 2'h1;
   localparam logic [2:0] BL_2   = 3'h1;
   localparam logic [2:0] BL_4   = 3'h2;
   localparam logic [2:0] BL_8   = 3'h3;
   localparam logic [2:0] CL_2   = 3'h2;
   localparam logic [2:0] CL_25  = 3'h6;
   localparam logic [3:0] LAT_H_2  = 4'h4;
   localparam logic [3:0] LAT_H_25 = 4'h5;
   localparam logic [12:0] MODE_RST  = 13'h0000;
   localparam logic [12:0] EMODE_RST = 13'h0001;
   // {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   typedef enum logic [1:0] {RD_IDLE, RD_LAT, RD_DATA} dsci_rd_e;
   typedef enum logic       {WR_IDLE, WR_DATA} dsci_wr_e;

   function automatic logic [3:0] bl_beats(input logic [2:0] code);
      bl_beats = (code == BL_8) ? 4'h8 : (code == BL_4) ? 4'h4 : 4'h2;
   endfunction

   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                  input logic [2:0] beat,
                                                  input logic [2:0] code,
                                                  input logic       inter);
      logic [2:0] mask;
      logic [2:0] off;
      mask = (code == BL_8) ? 3'h7 : (code == BL_4) ? 3'h3 : 3'h1;
      off  = inter ? (start[2:0] ^ beat) : 3'(start[2:0] + beat);
      burst_col = {start[COL_W-1:3], (start[2:0] & ~mask) | (off & mask)};
   endfunction
endpackage

// file: dsci_fifo.sv
// small valid/ready fifo for captured write beats
`timescale 1ns/10ps
`default_nettype none
module dsci_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_srst,
   // fill side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // drain side
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem_ff [DEPTH];
   logic [PW-1:0] wp_ff, nxt_wp_ff, rp_ff, nxt_rp_ff;
   logic [PW:0]   cnt_ff, nxt_cnt_ff;
   logic          push, pop;

   always_comb begin
      push = i_valid && (cnt_ff != (PW+1)'(DEPTH));
      pop  = i_ready && (cnt_ff != '0);
      nxt_wp_ff  = push ? ((wp_ff == PW'(DEPTH-1)) ? '0 : PW'(wp_ff + 1'b1)) : wp_ff;
      nxt_rp_ff  = pop  ? ((rp_ff == PW'(DEPTH-1)) ? '0 : PW'(rp_ff + 1'b1)) : rp_ff;
      nxt_cnt_ff = (PW+1)'(cnt_ff + push - pop);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff  <= nxt_wp_ff;
         rp_ff  <= nxt_rp_ff;
         cnt_ff <= nxt_cnt_ff;
      end
      if (push) begin
         mem_ff[wp_ff] <= i_data;
      end
   end

   assign o_ready = (cnt_ff != (PW+1)'(DEPTH));
   assign o_valid = (cnt_ff != '0);
   assign o_data  = mem_ff[rp_ff];
endmodule // dsci_fifo
`default_nettype wire

// file: dsci_ddr_dev.sv
// device side of the ddr command, strobe, mode and bank logic
//
// Summary of operation
// - commands sampled only at positive clock edge
// - write on both strobe edges, read both
// - device drives strobe only during reads
// - read strobe edges coincide with data
// - two strobes, lower and upper byte
// - two words per clock from prefetch
// - activate opens bank row before access
// - read/write address gives bank, start column
// - burst of 2, 4 or 8, sequential or interleaved
// - auto precharge closes row after burst
// - four banks, 8192 rows, 512 columns
// - clock enable low blocks commands; a running read still drives
// - precharge all leaves banks idle
// - mode register set by bank zero load
// - dll reset bit clears itself
// - mode fields: length, type, latency, op
`timescale 1ns/10ps
`default_nettype none
module dsci_ddr_dev
   import dsci_pkg::*;
#(
   parameter int MEM_AW_P = dsci_pkg::MEM_AW
) (
   // system clock and reset
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_srst,
   // link clock and command pins
   input  wire logic                        i_ck,
   input  wire logic                        i_ck_n,
   input  wire logic                        i_cke,
   input  wire logic                        i_cs_n,
   input  wire logic                        i_ras_n,
   input  wire logic                        i_cas_n,
   input  wire logic                        i_we_n,
   input  wire logic [dsci_pkg::BA_W-1:0]   i_ba,
   input  wire logic [dsci_pkg::AD_W-1:0]   i_addr,
   // data, strobes and masks
   input  wire logic [dsci_pkg::DQ_W-1:0]   i_dq,
   output logic      [dsci_pkg::DQ_W-1:0]   o_dq,
   output logic                             o_dq_oe,
   input  wire logic [1:0]                  i_dqs,
   output logic      [1:0]                  o_dqs,
   output logic                             o_dqs_oe,
   input  wire logic [1:0]                  i_dm,
   // status
   output logic      [dsci_pkg::AD_W-1:0]   o_mode,
   output logic      [dsci_pkg::AD_W-1:0]   o_emode,
   output logic                             o_dll_on,
   output logic                             o_dll_rst,
   output logic      [dsci_pkg::NBANK-1:0]  o_bank_open,
   output logic                             o_wr_drop
);
   localparam int SW = 2 + 5 + BA_W + AD_W + DQ_W + 2 + 2;
   localparam int FW = MEM_AW_P + 2 + DQ_W;

   // two flops on every pin; only the second stage is read by logic
   logic [SW-1:0] s1_ff, s2_ff;
   logic          ck_p_ff;
   logic [1:0]    dqs_p_ff;
   logic          ck_s, ckn_s, cke_s, cs_s, ras_s, cas_s, we_s;
   logic [1:0]    ba_s, dqs_s, dm_s;
   logic [AD_W-1:0] ad_s;
   logic [DQ_W-1:0] dq_s;
   logic          ck_rise, ck_fall, hedge, cmd_ok;
   logic [1:0]    dqs_edge;
   logic [2:0]    cmd;

   assign {ck_s, ckn_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, ad_s, dq_s, dqs_s, dm_s} = s2_ff;
   // positive edge: true rises while complement is low
   assign ck_rise  = ck_s && !ckn_s && !ck_p_ff;
   assign ck_fall  = !ck_s && ckn_s && ck_p_ff;
   assign hedge    = ck_rise || ck_fall;
   assign dqs_edge = dqs_s ^ dqs_p_ff;
   assign cmd      = {ras_s, cas_s, we_s};
   assign cmd_ok   = ck_rise && cke_s && !cs_s;

   // control state
   logic [AD_W-1:0]  mode_ff, nxt_mode_ff, emode_ff, nxt_emode_ff;
   logic             dll_on_ff, nxt_dll_on_ff, dll_rst_ff, nxt_dll_rst_ff;
   logic [NBANK-1:0] open_ff, nxt_open_ff;
   logic [AD_W-1:0]  row_ff [NBANK];
   logic [AD_W-1:0]  nxt_row_ff [NBANK];
   dsci_wr_e         wr_st_ff, nxt_wr_st_ff;
   logic [COL_W-1:0] wr_col_ff, nxt_wr_col_ff;
   logic [1:0]       wr_bank_ff, nxt_wr_bank_ff;
   logic [3:0]       wr_beat_ff, nxt_wr_beat_ff;
   logic             wr_ap_ff, nxt_wr_ap_ff, drop_ff, nxt_drop_ff;
   logic [7:0]       hi_lat_ff, nxt_hi_lat_ff;
   logic             f_in_v, f_in_r, f_out_v, f_out_r;
   logic [FW-1:0]    f_in_d, f_out_d;
   logic [COL_W-1:0] wcol;
   // read state
   dsci_rd_e         rd_st_ff, nxt_rd_st_ff;
   logic [COL_W-1:0] rd_col_ff, nxt_rd_col_ff;
   logic [1:0]       rd_bank_ff, nxt_rd_bank_ff;
   logic [3:0]       rd_beat_ff, nxt_rd_beat_ff, rd_beats_ff, nxt_rd_beats_ff;
   logic [3:0]       half_ff, nxt_half_ff;
   logic             rd_ap_ff, nxt_rd_ap_ff, rd_close;
   logic [2*DQ_W-1:0] pair_ff, nxt_pair_ff;
   logic [DQ_W-1:0]  dq_ff, nxt_dq_ff;
   logic [1:0]       dqs_ff, nxt_dqs_ff;
   logic             oe_ff, nxt_oe_ff, emit, rd_start;
   logic [3:0]       lat_h;
   logic [COL_W-1:0] c0, c1;
   // the array keeps only bank and low column bits; rows alias onto it
   logic [DQ_W-1:0]  mem_ff [2**MEM_AW_P];

   function automatic logic [MEM_AW_P-1:0] mem_idx(input logic [1:0] b,
                                                  input logic [COL_W-1:0] c);
      mem_idx = {b, c[MEM_AW_P-3:0]};
   endfunction

   always_comb begin
      nxt_mode_ff    = mode_ff;
      nxt_emode_ff   = emode_ff;
      nxt_dll_on_ff  = dll_on_ff;
      nxt_dll_rst_ff = 1'b0;
      nxt_open_ff    = open_ff;
      nxt_row_ff     = row_ff;
      nxt_wr_st_ff   = wr_st_ff;
      nxt_wr_col_ff  = wr_col_ff;
      nxt_wr_bank_ff = wr_bank_ff;
      nxt_wr_beat_ff = wr_beat_ff;
      nxt_wr_ap_ff   = wr_ap_ff;
      nxt_hi_lat_ff  = dqs_edge[1] ? dq_s[15:8] : hi_lat_ff;
      nxt_drop_ff    = 1'b0;
      f_in_v         = 1'b0;
      wcol = burst_col(wr_col_ff, wr_beat_ff[2:0], mode_ff[MR_BL_LSB+:3],
                       mode_ff[MR_BT_BIT]);
      f_in_d = {mem_idx(wr_bank_ff, wcol), ~dm_s,
                (dqs_edge[1] ? dq_s[15:8] : hi_lat_ff), dq_s[7:0]};
      if (cmd_ok) begin
         unique case (cmd)
            CMD_ACT: begin
               nxt_open_ff[ba_s] = 1'b1;
               nxt_row_ff[ba_s]  = ad_s;
            end
            CMD_PRE: begin
               if (ad_s[AP_BIT]) begin
                  nxt_open_ff = '0;
               end else begin
                  nxt_open_ff[ba_s] = 1'b0;
               end
            end
            CMD_MRS: begin
               if (ba_s == BA_MR) begin
                  nxt_mode_ff = ad_s;
                  nxt_mode_ff[MR_DLLRST_BIT] = 1'b0;
                  nxt_dll_rst_ff = ad_s[MR_DLLRST_BIT];
               end else if (ba_s == BA_EMR) begin
                  nxt_emode_ff  = ad_s;
                  nxt_dll_on_ff = !ad_s[EMR_DLLDIS_BIT];
               end
            end
            CMD_WR: begin
               if (open_ff[ba_s] && wr_st_ff == WR_IDLE) begin
                  nxt_wr_st_ff   = WR_DATA;
                  nxt_wr_bank_ff = ba_s;
                  nxt_wr_col_ff  = ad_s[COL_W-1:0];
                  nxt_wr_ap_ff   = ad_s[AP_BIT];
                  nxt_wr_beat_ff = '0;
               end
            end
            default: ;
         endcase
      end
      // lower strobe paces beats; upper byte comes from its own strobe
      if (wr_st_ff == WR_DATA && dqs_edge[0]) begin
         f_in_v         = f_in_r;
         nxt_drop_ff    = !f_in_r;
         nxt_wr_beat_ff = 4'(wr_beat_ff + 1'b1);
         if (nxt_wr_beat_ff == bl_beats(mode_ff[MR_BL_LSB+:3])) begin
            nxt_wr_st_ff = WR_IDLE;
            if (wr_ap_ff) begin
               nxt_open_ff[wr_bank_ff] = 1'b0;
            end
         end
      end
      if (rd_close) begin
         nxt_open_ff[rd_bank_ff] = 1'b0;
      end
      // an activate outranks a same-cycle auto precharge close
      if (cmd_ok && cmd == CMD_ACT) begin
         nxt_open_ff[ba_s] = 1'b1;
      end
   end

   always_comb begin
      nxt_rd_st_ff    = rd_st_ff;
      nxt_rd_col_ff   = rd_col_ff;
      nxt_rd_bank_ff  = rd_bank_ff;
      nxt_rd_beat_ff  = rd_beat_ff;
      nxt_rd_beats_ff = rd_beats_ff;
      nxt_rd_ap_ff    = rd_ap_ff;
      nxt_half_ff     = half_ff;
      nxt_pair_ff     = pair_ff;
      nxt_dq_ff       = dq_ff;
      nxt_dqs_ff      = dqs_ff;
      nxt_oe_ff       = oe_ff;
      rd_close        = 1'b0;
      emit            = 1'b0;
      lat_h = (mode_ff[MR_CL_LSB+:3] == CL_25) ? LAT_H_25 : LAT_H_2;
      rd_start = cmd_ok && cmd == CMD_RD && open_ff[ba_s] && rd_st_ff == RD_IDLE;
      c0 = burst_col(rd_col_ff, rd_beat_ff[2:0], mode_ff[MR_BL_LSB+:3],
                     mode_ff[MR_BT_BIT]);
      c1 = burst_col(rd_col_ff, 3'(rd_beat_ff[2:0] + 1'b1),
                     mode_ff[MR_BL_LSB+:3], mode_ff[MR_BT_BIT]);
      unique case (rd_st_ff)
         RD_IDLE: begin
            if (rd_start) begin
               nxt_rd_st_ff    = RD_LAT;
               nxt_rd_bank_ff  = ba_s;
               nxt_rd_col_ff   = ad_s[COL_W-1:0];
               nxt_rd_ap_ff    = ad_s[AP_BIT];
               nxt_rd_beats_ff = bl_beats(mode_ff[MR_BL_LSB+:3]);
               nxt_rd_beat_ff  = '0;
               nxt_half_ff     = '0;
            end
         end
         RD_LAT: begin
            if (hedge) begin
               nxt_half_ff = 4'(half_ff + 1'b1);
               if (nxt_half_ff == lat_h) begin
                  nxt_rd_st_ff = RD_DATA;
                  emit = 1'b1;
               end
            end
         end
         RD_DATA: begin
            if (hedge) begin
               if (rd_beat_ff == rd_beats_ff) begin
                  nxt_rd_st_ff = RD_IDLE;
                  nxt_oe_ff    = 1'b0;
                  rd_close     = rd_ap_ff;
               end else begin
                  emit = 1'b1;
               end
            end
         end
      endcase
      if (emit) begin
         // one double-width core fetch feeds two pin beats
         if (!rd_beat_ff[0]) begin
            nxt_pair_ff = {mem_ff[mem_idx(rd_bank_ff, c1)],
                           mem_ff[mem_idx(rd_bank_ff, c0)]};
            nxt_dq_ff   = mem_ff[mem_idx(rd_bank_ff, c0)];
         end else begin
            nxt_dq_ff   = pair_ff[2*DQ_W-1:DQ_W];
         end
         nxt_dqs_ff     = rd_beat_ff[0] ? 2'h0 : 2'h3;
         nxt_oe_ff      = 1'b1;
         nxt_rd_beat_ff = 4'(rd_beat_ff + 1'b1);
      end
   end

   // drain stalls during read data so the array has one user at a time
   assign f_out_r = (rd_st_ff != RD_DATA);

   dsci_fifo #(.W(FW), .DEPTH(FIFO_D)) u_wfifo (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_valid   (f_in_v),
      .o_ready   (f_in_r),
      .i_data    (f_in_d),
      .o_valid   (f_out_v),
      .i_ready   (f_out_r),
      .o_data    (f_out_d)
   );

   always_ff @(posedge i_clk_sys) begin
      s1_ff    <= {i_ck, i_ck_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba,
                   i_addr, i_dq, i_dqs, i_dm};
      s2_ff    <= s1_ff;
      ck_p_ff  <= ck_s;
      dqs_p_ff <= dqs_s;
      if (f_out_v && f_out_r) begin
         if (f_out_d[DQ_W]) begin
            mem_ff[f_out_d[FW-1:DQ_W+2]][7:0] <= f_out_d[7:0];
         end
         if (f_out_d[DQ_W+1]) begin
            mem_ff[f_out_d[FW-1:DQ_W+2]][15:8] <= f_out_d[15:8];
         end
      end
      if (i_srst) begin
         mode_ff <= MODE_RST;
         emode_ff <= EMODE_RST;
         dll_on_ff <= 1'b0;
         dll_rst_ff <= 1'b0;
         open_ff <= '0;
         row_ff <= '{default: '0};
         wr_st_ff <= WR_IDLE;
         wr_col_ff <= '0;
         wr_bank_ff <= '0;
         wr_beat_ff <= '0;
         wr_ap_ff <= 1'b0;
         hi_lat_ff <= '0;
         drop_ff <= 1'b0;
         rd_st_ff <= RD_IDLE;
         rd_col_ff <= '0;
         rd_bank_ff <= '0;
         rd_beat_ff <= '0;
         rd_beats_ff <= '0;
         rd_ap_ff <= 1'b0;
         half_ff <= '0;
         pair_ff <= '0;
         dq_ff <= '0;
         dqs_ff <= '0;
         oe_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode_ff;
         emode_ff <= nxt_emode_ff;
         dll_on_ff <= nxt_dll_on_ff;
         dll_rst_ff <= nxt_dll_rst_ff;
         open_ff <= nxt_open_ff;
         row_ff <= nxt_row_ff;
         wr_st_ff <= nxt_wr_st_ff;
         wr_col_ff <= nxt_wr_col_ff;
         wr_bank_ff <= nxt_wr_bank_ff;
         wr_beat_ff <= nxt_wr_beat_ff;
         wr_ap_ff <= nxt_wr_ap_ff;
         hi_lat_ff <= nxt_hi_lat_ff;
         drop_ff <= nxt_drop_ff;
         rd_st_ff <= nxt_rd_st_ff;
         rd_col_ff <= nxt_rd_col_ff;
         rd_bank_ff <= nxt_rd_bank_ff;
         rd_beat_ff <= nxt_rd_beat_ff;
         rd_beats_ff <= nxt_rd_beats_ff;
         rd_ap_ff <= nxt_rd_ap_ff;
         half_ff <= nxt_half_ff;
         pair_ff <= nxt_pair_ff;
         dq_ff <= nxt_dq_ff;
         dqs_ff <= nxt_dqs_ff;
         oe_ff <= nxt_oe_ff;
      end
   end

   assign o_dq        = dq_ff;
   assign o_dq_oe     = oe_ff;
   assign o_dqs       = dqs_ff;
   assign o_dqs_oe    = oe_ff;
   assign o_mode      = mode_ff;
   assign o_emode     = emode_ff;
   assign o_dll_on    = dll_on_ff;
   assign o_dll_rst   = dll_rst_ff;
   assign o_bank_open = open_ff;
   assign o_wr_drop   = drop_ff;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);

   cmd_edge_a: assert property ($changed(mode_ff) |-> $past(ck_rise))
      else $error("mode changed away from a clock rise");
   wr_pace_a: assert property ((wr_st_ff == WR_DATA && !dqs_edge[0])
      |=> wr_beat_ff == $past(wr_beat_ff))
      else $error("write beat moved without strobe edge");
   dqs_own_a: assert property (oe_ff |-> rd_st_ff == RD_DATA)
      else $error("strobe driven outside read data");
   edge_align_a: assert property ((rd_st_ff == RD_DATA && $changed(rd_beat_ff))
      |-> $changed(dqs_ff))
      else $error("read data moved without strobe edge");
   two_strobe_a: assert property (dqs_ff[0] == dqs_ff[1])
      else $error("byte strobes disagree");
   prefetch_a: assert property ($changed(pair_ff) |-> !$past(rd_beat_ff[0]))
      else $error("core fetch on odd beat");
   bank_act_a: assert property ((cmd_ok && cmd == CMD_ACT)
      |=> open_ff[$past(ba_s)] && row_ff[$past(ba_s)] == $past(ad_s))
      else $error("activate did not open row");
   rd_bank_a: assert property (rd_start |=> rd_bank_ff == $past(ba_s)
      && rd_col_ff == $past(ad_s[COL_W-1:0]))
      else $error("read start address not captured");
   burst_len_a: assert property ((rd_st_ff == RD_DATA && hedge
      && rd_beat_ff == rd_beats_ff) |=> rd_st_ff == RD_IDLE && !oe_ff)
      else $error("read burst did not end");
   auto_pre_a: assert property ((rd_st_ff == RD_DATA && hedge && rd_ap_ff
      && rd_beat_ff == rd_beats_ff && !(cmd_ok && cmd == CMD_ACT && ba_s == rd_bank_ff))
      |=> !open_ff[$past(rd_bank_ff)])
      else $error("auto precharge missed");
   idle_hiz_a: assert property ((rd_st_ff == RD_IDLE) |-> !oe_ff)
      else $error("outputs driven while idle");
   dll_clear_a: assert property (dll_rst_ff |=> !dll_rst_ff
      && !mode_ff[MR_DLLRST_BIT])
      else $error("dll reset did not self clear");
   mode_hold_a: assert property (!(cmd_ok && cmd == CMD_MRS) |=> $stable(mode_ff))
      else $error("mode changed without load");
endmodule // dsci_ddr_dev
`default_nettype wire

// file: dsci_ctl_model.sv
// controller model: link clock, command pins and write strobes
`timescale 1ns/10ps
`default_nettype none
module dsci_ctl_model
   import dsci_pkg::*;
(
   // system clock
   input  wire logic        i_clk_sys,
   // link pins
   output logic             o_ck,
   output logic             o_cke,
   output logic             o_cs_n,
   output logic [2:0]       o_cmd,
   output logic [BA_W-1:0]  o_ba,
   output logic [AD_W-1:0]  o_addr,
   // write data
   output logic [DQ_W-1:0]  o_dq,
   output logic [1:0]       o_dqs,
   output logic [1:0]       o_dm
);
   logic [1:0] div_ff;
   logic       wr_on;
   initial begin
      {div_ff, o_ck, o_cke, o_dqs, o_dm, wr_on} = '0;
      {o_cs_n, o_cmd, o_ba, o_addr, o_dq} = '1;
   end
   // free link clock; a released data bus never holds a stale value
   always @(negedge i_clk_sys) begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) o_ck <= ~o_ck;
      if (!wr_on) o_dq <= ~o_dq;
   end
   task automatic pwr_up();
      repeat (2000) @(negedge i_clk_sys); // enable low for 200 us
      o_cmd = CMD_NOP;
      @(negedge o_ck);
      o_cs_n = 1'b0; // nop, then enable
      o_cke = 1'b1;
   endtask
   // pins move half a link cycle before the rise, nop afterwards
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
      @(negedge o_ck);
      {o_cmd, o_ba, o_addr} = {c, b, a};
      @(posedge o_ck);
      @(negedge o_ck);
      o_cmd = CMD_NOP;
   endtask
   task automatic wr(input int n, input logic [15:0] d, input logic [1:0] m0);
      wr_on = 1'b1;
      @(negedge i_clk_sys);
      for (int k = 0; k < n; k++) begin
         o_dq = d + 16'(k);
         o_dm = (k == 0) ? m0 : 2'b00;
         repeat (2) @(negedge i_clk_sys);
         o_dqs = ~o_dqs; // both strobes, centred in data
         repeat (2) @(negedge i_clk_sys);
      end
      wr_on = 1'b0;
   endtask
endmodule // dsci_ctl_model
`default_nettype wire

// file: testbench.sv
// bench: power-up sequence, mode loads and bursts of every length
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dsci_pkg::*;
   logic clk, srst, ck, cke, cs_n, dq_oe, dqs_oe, dll_on, dll_rst, wr_drop, seen;
   logic [2:0] cmd;
   logic [1:0] ba, c_dqs, d_dqs, dm;
   logic [12:0] addr, mode, emode;
   logic [15:0] c_dq, d_dq;
   logic [3:0] open;
   logic [15:0] mem [4][8];
   int err_count, compares, pulses, drops, cnt;
   dsci_ctl_model m (.i_clk_sys(clk), .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd),
      .o_ba(ba), .o_addr(addr), .o_dq(c_dq), .o_dqs(c_dqs), .o_dm(dm));
   dsci_ddr_dev dut (.i_clk_sys(clk), .i_srst(srst), .i_ck(ck), .i_ck_n(~ck), .i_cke(cke),
      .i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
      .i_addr(addr), .i_dq(dq_oe ? d_dq : c_dq), .o_dq(d_dq), .o_dq_oe(dq_oe),
      .i_dqs(dqs_oe ? d_dqs : c_dqs), .o_dqs(d_dqs), .o_dqs_oe(dqs_oe), .i_dm(dm),
      .o_mode(mode), .o_emode(emode), .o_dll_on(dll_on), .o_dll_rst(dll_rst),
      .o_bank_open(open), .o_wr_drop(wr_drop));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) if (dll_rst === 1'b1) pulses <= pulses + 1;
   always @(negedge clk) if (wr_drop === 1'b1) drops <= drops + 1;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // own burst order: wrap inside the aligned block
   function automatic logic [2:0] tcol(input logic [2:0] s, input int k, input int n,
                                       input logic il);
      logic [2:0] msk;
      msk = 3'(n - 1);
      tcol = (s & ~msk) | ((il ? (s ^ 3'(k)) : (s + 3'(k))) & msk);
   endfunction
   task automatic burst(input int i);
      logic [1:0] b;
      logic [2:0] c, rs;
      logic [15:0] d;
      int n;
      b = 2'(i % 4);
      n = 2 << (i / 2);
      rs = tcol(3'h5, 1, n, 1'b0);
      m.cmd(CMD_MRS, BA_MR, {6'h0, (i[0] ? CL_25 : CL_2), i[0], 3'(i / 2 + 1)});
      m.cmd(CMD_ACT, b, 13'h0005);
      m.cmd(CMD_WR, b, (i == 5) ? 13'h0405 : 13'h0005);
      chk("bank open", 16'(4'h1 << b), 16'(open));
      m.wr(n, 16'(i) * 16'h1111, (i > 3) ? 2'b01 : 2'b00);
      if (i == 5) begin
         repeat (3) @(negedge clk);
         chk("write precharge", 0, 16'(open[b]));
         m.cmd(CMD_ACT, b, 13'h0005);
      end
      for (int k = 0; k < n; k++) begin
         c = tcol(3'h5, k, n, i[0]);
         d = 16'(i) * 16'h1111 + 16'(k);
         if (k == 0 && i > 3) d[7:0] = mem[b][c][7:0];
         mem[b][c] = d;
      end
      m.cmd(CMD_RD, b, 13'h0400 | 13'(rs));
      cnt = 0;
      while (dq_oe !== 1'b1 && cnt < 40) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt == 40) begin
         err_count++;
         tally_and_finish();
      end
      chk("latency", 1, 16'(cnt > (i[0] ? 16 : 12) && cnt < (i[0] ? 24 : 20)));
      for (int k = 0; k < n; k++) begin
         chk("read data", mem[b][tcol(rs, k, n, i[0])], d_dq);
         chk("read strobe", k[0] ? 16'h0 : 16'h3, 16'(d_dqs));
         repeat (4) @(negedge clk);
      end
      repeat (2) @(negedge clk);
      chk("read drive", 0, 16'(dqs_oe));
      chk("bank closed", 0, 16'(open[b]));
   endtask
   initial begin
      srst = 1'b1;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      chk("emode", 16'(EMODE_RST), 16'(emode));
      chk("dq drive", 0, 16'(dq_oe));
      m.pwr_up();
      m.cmd(CMD_PRE, 2'h0, 13'h0400);
      m.cmd(CMD_MRS, BA_EMR, 13'h0000);
      chk("emode load", 0, 16'(emode));
      m.cmd(CMD_MRS, BA_MR, 13'h0122);
      chk("dll on", 1, 16'(dll_on));
      repeat (200) m.cmd(CMD_NOP, 2'h0, 13'h0000);
      chk("dll reset", 1, 16'(pulses));
      chk("mode", 16'h0022, 16'(mode));
      m.cmd(CMD_PRE, 2'h0, 13'h0400);
      repeat (2) m.cmd(CMD_REF, 2'h0, 13'h0000);
      m.cmd(CMD_MRS, 2'h2, 13'h1fff);
      chk("mode kept", 16'h0022, 16'(mode));
      m.cmd(CMD_MRS, BA_MR, 13'h0023);
      chk("mode reload", 16'h0023, 16'(mode));
      for (int i = 0; i < 6; i++) burst(i);
      m.cmd(CMD_RD, 2'h3, 13'h0000);
      seen = 1'b0;
      repeat (30) begin
         @(negedge clk);
         seen = seen | dq_oe;
      end
      chk("closed read", 0, 16'(seen));
      chk("dll pulses", 1, 16'(pulses));
      chk("write drops", 0, 16'(drops));
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
